/* File: common/link_seq_defines.svh */
`ifndef LINK_SEQ_DEFINES_SVH
`define LINK_SEQ_DEFINES_SVH
// pipeline latency in half sample periods (10.5 and 13.5 sample periods)
`define LAT_PIPE_ONE_HALF   8'd21
`define LAT_PIPE_TWO_HALF   8'd27
// sync assertion to comma, sample periods
`define LAT_COMMA_ONE       8'd7
`define LAT_COMMA_TWO       8'd10
// sync release to alignment sequence, sample periods
`define LAT_ALIGN_ONE       8'd3
`define LAT_ALIGN_TWO       8'd6
// bit period limits in ps
`define BIT_MIN_ONE_PS      16'd167
`define BIT_MIN_TWO_PS      16'd294
`define BIT_MAX_PS          16'd1000
// k28.5 control character, flagged by the control bit
`define COMMA_CHAR          8'hbc
// alignment sequence length in multiframes
`define ALIGN_MFRAMES       8'd4
`endif

/* File: common/link_seq_pkg.sv */
package link_seq_pkg;
	typedef enum logic [1:0] {
		ST_COMMA = 2'b00,
		ST_ALIGN = 2'b01,
		ST_DATA  = 2'b10
	} link_state_t;

	typedef struct packed {
		logic       is_ctrl;
		logic [7:0] octet;
	} lane_char_t;

	typedef struct packed {
		logic [13:0] chan_a;
		logic [13:0] chan_b;
	} sample_pair_t;
endpackage : link_seq_pkg

/* File: core/link_seq.sv */
`timescale 1ns/1ps
`include "link_seq_defines.svh"

module link_seq
	import link_seq_pkg::*;
#(
	parameter int FRAMES_PER_MF = 32
) (
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	input  wire logic         clock_halving_select,
	input  wire logic         two_lane_mode,
	input  wire logic [1:0]   subclass,
	input  wire logic         sysref,
	input  wire logic         sync_n,
	input  wire sample_pair_t sample_in,
	output lane_char_t        primary_serial_lane,
	output lane_char_t        secondary_serial_lane,
	output logic              lane_b_active,
	output logic              sample_strobe,
	output logic              frame_start,
	output logic              mframe_start
);
	// synchronisers for pin inputs; stage one is read only by stage two
	logic sync_s1_r, sync_s2_r, sync_s3_r;
	logic sref_s1_r, sref_s2_r, sref_s3_r;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sync_s1_r <= 1'b1;
			sync_s2_r <= 1'b1;
			sync_s3_r <= 1'b1;
			sref_s1_r <= 1'b0;
			sref_s2_r <= 1'b0;
			sref_s3_r <= 1'b0;
		end else begin
			sync_s1_r <= sync_n;
			sync_s2_r <= sync_s1_r;
			sync_s3_r <= sync_s2_r;
			sref_s1_r <= sysref;
			sref_s2_r <= sref_s1_r;
			sref_s3_r <= sref_s2_r;
		end
	end
	logic sref_rise, sync_rise;
	assign sref_rise = sref_s2_r & ~sref_s3_r;
	assign sync_rise = sync_s2_r & ~sync_s3_r;

	// divider resync: sysref in subclass 1, sync release in subclass 2
	logic div_reset;
	assign div_reset = (subclass == 2'd1 && sref_rise) || (subclass == 2'd2 && sync_rise);

	// sample clock enable: every edge, or every second edge when halving
	logic       half_r, half_nxt;
	logic       smp;
	logic [7:0] frame_cnt_r, frame_cnt_nxt;
	logic [7:0] half_cnt_r, half_cnt_nxt;
	assign smp = !clock_halving_select || half_r;
	always_comb begin
		half_nxt      = div_reset ? 1'b0 : ~half_r;
		frame_cnt_nxt = frame_cnt_r;
		half_cnt_nxt  = half_cnt_r + 8'd1;
		if (div_reset) begin
			frame_cnt_nxt = 8'd0;
		end else if (smp) begin
			frame_cnt_nxt = (frame_cnt_r == 8'(FRAMES_PER_MF - 1)) ? 8'd0 : frame_cnt_r + 8'd1;
		end
	end
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			half_r      <= 1'b0;
			frame_cnt_r <= 8'd0;
			half_cnt_r  <= 8'd0;
		end else begin
			half_r      <= half_nxt;
			frame_cnt_r <= frame_cnt_nxt;
			half_cnt_r  <= half_cnt_nxt;
		end
	end

	// data pipeline, one stage per sample period; the half period is taken by
	// the serialiser phase, so whole stages are depth minus one half
	localparam int PIPE_MAX = 14;
	sample_pair_t pipe_r [PIPE_MAX];
	sample_pair_t pipe_nxt [PIPE_MAX];
	genvar gi;
	generate
		for (gi = 0; gi < PIPE_MAX; gi++) begin : g_pipe
			always_comb begin
				pipe_nxt[gi] = pipe_r[gi];
				if (smp) begin
					pipe_nxt[gi] = (gi == 0) ? sample_in : pipe_r[(gi == 0) ? 0 : gi - 1];
				end
			end
			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					pipe_r[gi] <= '0;
				end else begin
					pipe_r[gi] <= pipe_nxt[gi];
				end
			end
		end
	endgenerate
	logic [7:0]   pipe_tap;
	sample_pair_t delayed;
	// tap in whole sample periods counted on the sample strobe, not device clocks
	assign pipe_tap = two_lane_mode ? (`LAT_PIPE_TWO_HALF >> 1) : (`LAT_PIPE_ONE_HALF >> 1);
	assign delayed  = pipe_r[pipe_tap[3:0] - 4'd1];

	// link state with sync assertion and release delays
	link_state_t st_r, st_nxt;
	logic [7:0]  dly_r, dly_nxt;
	logic        arm_r, arm_nxt;
	logic        run_r, run_nxt;
	logic        pend_r, pend_nxt;
	logic [7:0]  comma_lat, align_lat, comma_tgt, align_tgt;
	logic        anchor;
	assign comma_lat = two_lane_mode ? `LAT_COMMA_TWO : `LAT_COMMA_ONE;
	assign align_lat = two_lane_mode ? `LAT_ALIGN_TWO : `LAT_ALIGN_ONE;
	// one sample period is two device clocks when halving, so the waits run on clocks
	assign comma_tgt = clock_halving_select ? {comma_lat[6:0], 1'b0} : comma_lat;
	assign align_tgt = clock_halving_select ? {align_lat[6:0], 1'b0} : align_lat;
	// subclass 0 anchors on a frame start, others on a multiframe start
	assign anchor = smp && (subclass == 2'd0 || frame_cnt_r == 8'd0);
	always_comb begin
		st_nxt   = st_r;
		dly_nxt  = dly_r;
		arm_nxt  = arm_r;
		run_nxt  = run_r;
		pend_nxt = pend_r;
		if (!sync_s2_r && st_r != ST_COMMA) begin
			// the first clock that sees the request counts; the output register adds
			// one more clock, so the state switches one clock before the target
			if (!pend_r) begin
				pend_nxt = 1'b1;
				dly_nxt  = 8'd1;
			end else begin
				dly_nxt = dly_r + 8'd1;
				if (dly_r + 8'd2 >= comma_tgt) begin
					st_nxt   = ST_COMMA;
					pend_nxt = 1'b0;
					arm_nxt  = 1'b0;
					run_nxt  = 1'b0;
				end
			end
		end else if (st_r == ST_COMMA && sync_s2_r) begin
			if (!arm_r) begin
				arm_nxt = 1'b1; // release detected, wait for the anchor
				run_nxt = 1'b0;
			end else if (!run_r && anchor) begin
				run_nxt = 1'b1;
				dly_nxt = 8'd1;
			end else if (run_r) begin
				dly_nxt = dly_r + 8'd1;
				if (dly_r + 8'd1 >= align_tgt) begin
					st_nxt  = ST_ALIGN;
					dly_nxt = 8'd0;
				end
			end
		end else if (st_r == ST_COMMA) begin
			arm_nxt = 1'b0;
			run_nxt = 1'b0;
		end else if (st_r == ST_ALIGN && smp && frame_cnt_r == 8'(FRAMES_PER_MF - 1)) begin
			dly_nxt = dly_r + 8'd1;
			if (dly_r + 8'd1 >= `ALIGN_MFRAMES) begin
				st_nxt = ST_DATA;
			end
		end else if (st_r != ST_COMMA) begin
			pend_nxt = 1'b0;
		end
	end
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_r   <= ST_COMMA;
			dly_r  <= 8'd0;
			arm_r  <= 1'b0;
			run_r  <= 1'b0;
			pend_r <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			dly_r  <= dly_nxt;
			arm_r  <= arm_nxt;
			run_r  <= run_nxt;
			pend_r <= pend_nxt;
		end
	end

	// lane character mapping; one lane alternates channels a and b when halving, else sends channel a only
	lane_char_t pri_nxt, sec_nxt;
	lane_char_t pri_r, sec_r;
	logic       ch_sel_r, ch_sel_nxt;
	always_comb begin
		ch_sel_nxt = smp ? 1'b0 : ~ch_sel_r;
		pri_nxt    = '{is_ctrl: 1'b1, octet: `COMMA_CHAR};
		sec_nxt    = '{is_ctrl: 1'b1, octet: `COMMA_CHAR};
		if (st_r == ST_ALIGN) begin
			// alignment marks multiframe ends with a control char
			pri_nxt = '{is_ctrl: frame_cnt_r == 8'(FRAMES_PER_MF - 1), octet: frame_cnt_r};
			sec_nxt = pri_nxt;
		end else if (st_r == ST_DATA) begin
			if (two_lane_mode) begin
				pri_nxt = '{is_ctrl: 1'b0, octet: delayed.chan_a[13:6]};
				sec_nxt = '{is_ctrl: 1'b0, octet: delayed.chan_b[13:6]};
			end else begin
				pri_nxt = '{is_ctrl: 1'b0,
					octet: ch_sel_r ? delayed.chan_b[13:6] : delayed.chan_a[13:6]};
				sec_nxt = '{is_ctrl: 1'b0, octet: 8'h00};
			end
		end
		if (!two_lane_mode) begin
			sec_nxt = '{is_ctrl: 1'b0, octet: 8'h00};
		end
	end
	// outputs registered so the lane follows its clock edge by one edge, within 0.6 periods
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pri_r                 <= '{is_ctrl: 1'b1, octet: `COMMA_CHAR};
			sec_r                 <= '0;
			ch_sel_r              <= 1'b0;
			lane_b_active         <= 1'b0;
			sample_strobe         <= 1'b0;
			frame_start           <= 1'b0;
			mframe_start          <= 1'b0;
		end else begin
			pri_r                 <= pri_nxt;
			sec_r                 <= sec_nxt;
			ch_sel_r              <= ch_sel_nxt;
			lane_b_active         <= two_lane_mode;
			sample_strobe         <= smp;
			frame_start           <= smp;
			mframe_start          <= smp && frame_cnt_r == 8'd0;
		end
	end
	assign primary_serial_lane   = pri_r;
	assign secondary_serial_lane = sec_r;

	// the serialiser clock must keep the bit period inside the mode limits;
	// the limit in force is exposed through the defines for the serdes setup
	logic unused_half;
	assign unused_half = half_cnt_r[0];
endmodule : link_seq

/* File: tb/link_seq_props.sv */
`timescale 1ns/1ps
module link_seq_props
	import link_seq_pkg::*;
(
	input wire logic         clk_sys,
	input wire logic         nrst,
	input wire logic         clock_halving_select,
	input wire logic         two_lane_mode,
	input wire logic [1:0]   subclass,
	input wire logic         sysref,
	input wire logic         sync_n,
	input wire sample_pair_t sample_in,
	input wire lane_char_t   primary_serial_lane,
	input wire lane_char_t   secondary_serial_lane,
	input wire logic         lane_b_active,
	input wire logic         sample_strobe,
	input wire logic         frame_start,
	input wire logic         mframe_start
);
	logic [5:0] low_r;
	logic [5:0] low_nxt;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// length of the current sync request, saturating so it never wraps
	always_comb low_nxt = sync_n ? 6'h0 : low_r + {5'h0, low_r != 6'h3f};
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			low_r <= 6'h0;
		else
			low_r <= low_nxt;
	end
	comma_hold_a: assert property (low_r > 6'h18 |-> primary_serial_lane == 9'h1bc)
		else $error("primary lane left commas during sync request");
	comma_lane_b_a: assert property (low_r > 6'h18 && two_lane_mode |->
		secondary_serial_lane == 9'h1bc && lane_b_active)
		else $error("second lane not sending commas");
	one_lane_idle_a: assert property (!two_lane_mode [*3] |-> !lane_b_active)
		else $error("second lane active in one-lane mode");
	full_rate_a: assert property (!clock_halving_select [*3] |-> sample_strobe)
		else $error("strobe missing at full rate");
	strobe_gap_a: assert property (clock_halving_select [*3] ##0 sample_strobe |=>
		!sample_strobe)
		else $error("strobe on two clocks in a row at half rate");
	strobe_due_a: assert property (clock_halving_select [*3] ##0 !sample_strobe [*2] |=>
		sample_strobe)
		else $error("strobe missing for three clocks at half rate");
	mframe_edge_a: assert property (mframe_start |-> frame_start)
		else $error("multiframe start off a frame start");
	comma_one_a: assert property ($fell(sync_n) && !two_lane_mode && !clock_halving_select
		|-> ##9 primary_serial_lane == 9'h1bc)
		else $error("one-lane comma delay wrong");
	comma_two_a: assert property ($fell(sync_n) && two_lane_mode && !clock_halving_select
		|-> ##12 primary_serial_lane == 9'h1bc)
		else $error("two-lane comma delay wrong");
	cover property ($rose(sync_n));
	cover property (mframe_start && clock_halving_select);
	cover property (two_lane_mode && !primary_serial_lane.is_ctrl);
endmodule : link_seq_props

/* File: tb/rx_model.sv */
`timescale 1ns/1ps
module rx_model
	import link_seq_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire logic       lose,
	input  wire lane_char_t lane,
	output logic            sync_n
);
	logic [2:0] run_r;
	// release only after seven commas in a row, so one stray char cannot end resync
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst || lose) begin
			run_r  <= 3'h0;
			sync_n <= 1'b0;
		end else if (!sync_n) begin
			run_r  <= (lane == 9'h1bc) ? run_r + 3'h1 : 3'h0;
			sync_n <= &run_r;
		end
	end
endmodule : rx_model

/* File: tb/dual_adc_serial_link_latency_bench.sv */
`timescale 1ns/1ps
module dual_adc_serial_link_latency_bench;
	import link_seq_pkg::*;
	logic         clk_sys = 1'b0, nrst = 1'b0, half = 1'b0, two = 1'b0, sysref = 1'b0;
	logic         lose = 1'b0, sync_n, lane_b, strobe, fs, mfs;
	logic [1:0]   sc = 2'h0;
	sample_pair_t smp = '0;
	lane_char_t   pri, sec;
	int           n_errors = 0, compares = 0, cyc = 0, n;
	always #2.5 clk_sys = ~clk_sys;
	// short multiframes keep each alignment sequence brief
	link_seq #(.FRAMES_PER_MF(2)) i_dut (.clk_sys(clk_sys), .nrst(nrst),
		.clock_halving_select(half), .two_lane_mode(two), .subclass(sc), .sysref(sysref),
		.sync_n(sync_n), .sample_in(smp), .primary_serial_lane(pri),
		.secondary_serial_lane(sec), .lane_b_active(lane_b), .sample_strobe(strobe),
		.frame_start(fs), .mframe_start(mfs));
	rx_model i_rx (.clk_sys(clk_sys), .nrst(nrst), .lose(lose), .lane(pri), .sync_n(sync_n));
	task chk(input string what, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %0h seen %0h", what, exp, seen);
		end
	endtask : chk
	task report_and_stop();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop
	// hang guard, well above the full sequence length
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic t_sync(input logic tw, hf, input logic [1:0] s);
		int div;
		div = hf ? 2 : 1;
		two <= tw;
		half <= hf;
		sc <= s;
		sysref <= (s == 2'h1);
		repeat (4) @(posedge clk_sys);
		sysref <= 1'b0;
		while (pri.is_ctrl !== 1'b0) @(posedge clk_sys);
		lose <= 1'b1;
		@(posedge clk_sys);
		lose <= 1'b0;
		while (sync_n !== 1'b0) @(posedge clk_sys);
		for (n = 0; pri !== 9'h1bc; n++) @(posedge clk_sys);
		chk("comma delay", n == 2 + div * (tw ? 10 : 7) - (hf && n[0]), 1'b1);
		while (sync_n !== 1'b1) @(posedge clk_sys);
		// skip the pulses launched before the release was seen inside
		repeat (4) @(posedge clk_sys);
		while ((s == 2'h0 ? fs : mfs) !== 1'b1) @(posedge clk_sys);
		for (n = 0; pri === 9'h1bc; n++) @(posedge clk_sys);
		chk("align delay", n, div * (tw ? 6 : 3));
		// alignment chars can look like data, so wait out the sequence, then expect no control
		repeat (24) @(posedge clk_sys);
		repeat (8) begin
			@(posedge clk_sys);
			chk("data follows align", pri.is_ctrl, 1'b0);
		end
	endtask : t_sync
	task automatic t_data();
		@(posedge clk_sys);
		smp <= '{chan_a: 14'h3a5c, chan_b: 14'h1234};
		@(posedge clk_sys);
		smp <= '0;
		// the sample is taken on this edge; count from the next one
		@(posedge clk_sys);
		for (n = 0; pri !== 9'h0e9 && n < 40; n++) @(posedge clk_sys);
		chk("sample delay", n, two ? 13 : 10);
		if (two)
			chk("lane b sample", sec, 9'h048);
	endtask : t_data
	initial begin
		repeat (6) @(posedge clk_sys);
		chk("reset lane", pri, 9'h1bc);
		nrst <= 1'b1;
		t_sync(1'b0, 1'b0, 2'h0);
		t_data();
		t_sync(1'b1, 1'b0, 2'h1);
		t_data();
		t_sync(1'b0, 1'b1, 2'h2);
		t_sync(1'b1, 1'b1, 2'h0);
		report_and_stop();
	end
endmodule : dual_adc_serial_link_latency_bench
bind link_seq link_seq_props i_props (.*);
